// *** common/scrf_pkg.sv ***
package scrf_pkg;
	localparam int          BYTE_W     = 8;
	localparam logic [7:0]  HDR_BYTE   = 8'hA5;
	localparam logic [7:0]  REQ_MAX    = 8'hFA;
	localparam logic [7:0]  RSP_MAX    = 8'hF8;
	localparam logic [15:0] CRC_POLY   = 16'h1021;
	localparam logic [15:0] CRC_INIT   = 16'hFFFF;
	localparam int          FIFO_WIDTH = 8;
	localparam int          FIFO_DEPTH = 8;

	typedef enum logic [6:0] {
		RX_HUNT = 7'h01,
		RX_LEN  = 7'h02,
		RX_CMD  = 7'h04,
		RX_DAT  = 7'h08,
		RX_CRH  = 7'h10,
		RX_CRL  = 7'h20,
		RX_HOLD = 7'h40
	} scrf_rx_state_t;

	typedef enum logic [9:0] {
		TX_IDLE = 10'h001,
		TX_HDR  = 10'h002,
		TX_LEN  = 10'h004,
		TX_CMD  = 10'h008,
		TX_STH  = 10'h010,
		TX_STL  = 10'h020,
		TX_DAT  = 10'h040,
		TX_CRH  = 10'h080,
		TX_CRL  = 10'h100,
		TX_END  = 10'h200
	} scrf_tx_state_t;
endpackage : scrf_pkg

// *** common/scrf_stream_if.sv ***
`timescale 1ns/10ps
interface scrf_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : scrf_stream_if

// *** core/scrf_fifo.sv ***
`timescale 1ns/10ps
module scrf_fifo #(
	parameter int WIDTH = scrf_pkg::FIFO_WIDTH,
	parameter int DEPTH = scrf_pkg::FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic  clk_sys,
	input  wire logic  rst_n,
	// Filling and draining sides.
	scrf_stream_if.snk wr,
	scrf_stream_if.src rd
);
	import scrf_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW-1:0]    rd_ptr_next;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             ready_reg;
	logic             ready_next;
	logic             push;
	logic             pop;

	assign push     = wr.valid && ready_reg;
	assign pop      = rd.valid && rd.ready;
	assign wr.ready = ready_reg;
	assign rd.valid = (count_reg != '0);
	assign rd.data  = mem[rd_ptr_reg];

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		if (push) begin
			wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
		end
		if (pop) begin
			rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
		end
		count_next = count_reg + CW'(push) - CW'(pop);
		// Ready is registered so the filling side never sees a combinational path.
		ready_next = (count_next != CW'(DEPTH));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
			ready_reg  <= ready_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg] <= wr.data;
		end
	end

	fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(count_reg == CW'(DEPTH)) |-> !ready_reg && rd.valid)
		else $error("Full buffer still offers room or hides its data.");
endmodule : scrf_fifo

// *** core/scrf_crc16.sv ***
`timescale 1ns/10ps
module scrf_crc16 (
	// Clock and reset.
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	// Byte feed.
	input  wire logic                         init,
	input  wire logic                         en,
	input  wire logic [scrf_pkg::BYTE_W-1:0]  data,
	// Running checksum.
	output logic      [15:0]                  crc
);
	import scrf_pkg::*;

	logic [15:0] crc_reg;
	logic [15:0] crc_next;
	logic [15:0] c;
	logic        fb;

	assign crc = crc_reg;

	always_comb begin
		c  = crc_reg;
		fb = 1'b0;
		// Bitwise, most significant bit first.
		for (int i = 0; i < 8; i++) begin
			fb = c[15] ^ data[7 - i];
			c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		crc_next = crc_reg;
		if (init) begin
			crc_next = CRC_INIT;
		end else if (en) begin
			crc_next = c;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crc_reg <= CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

	crc_preset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		init |=> crc == CRC_INIT)
		else $error("Checksum not preset to all ones.");
	crc_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!init && !en) |=> $stable(crc))
		else $error("Checksum moved without a counted byte.");
endmodule : scrf_crc16

// *** core/scrf_framer.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - A response is only sent while a received command is pending.
// - One command at a time; receiving stops until its response is sent.
// - Request is header, length, command, 0..250 data, checksum high then low.
// - Response is header, length, command, status word, 0..248 data, checksum.
// - Both directions use the same CCITT 16-bit CRC.
// - Checksum covers length, command, status and data in sending order.
// - The header byte is left out of the checksum.
module scrf_framer (
	// Clock and reset.
	input  wire logic                         clk_sys,
	input  wire logic                         resetn,
	// Host link, receive side.
	input  wire logic                         rx_valid,
	input  wire logic [scrf_pkg::BYTE_W-1:0]  rx_data,
	output logic                              rx_ready,
	// Host link, transmit side.
	output logic                              tx_valid,
	output logic      [scrf_pkg::BYTE_W-1:0]  tx_data,
	input  wire logic                         tx_ready,
	// Command handed to the command processor.
	output logic                              cmd_valid,
	output logic      [scrf_pkg::BYTE_W-1:0]  cmd_code,
	output logic      [scrf_pkg::BYTE_W-1:0]  cmd_len,
	output logic                              cmd_pending,
	output logic                              rx_drop,
	input  wire logic [scrf_pkg::BYTE_W-1:0]  rd_addr,
	output logic      [scrf_pkg::BYTE_W-1:0]  rd_data,
	// Response from the command processor.
	input  wire logic                         rsp_start,
	input  wire logic [15:0]                  rsp_status,
	input  wire logic [scrf_pkg::BYTE_W-1:0]  rsp_len,
	output logic                              rsp_accept,
	input  wire logic                         app_tx_valid,
	input  wire logic [scrf_pkg::BYTE_W-1:0]  app_tx_data,
	output logic                              app_tx_ready
);
	import scrf_pkg::*;

	logic [1:0]        rst_sync_reg;
	logic              rst_n;
	scrf_rx_state_t    rx_state_reg;
	scrf_rx_state_t    rx_state_next;
	logic [7:0]        rx_len_reg;
	logic [7:0]        rx_len_next;
	logic [7:0]        rx_cmd_reg;
	logic [7:0]        rx_cmd_next;
	logic [7:0]        rx_idx_reg;
	logic [7:0]        rx_idx_next;
	logic [7:0]        rx_crc_hi_reg;
	logic [7:0]        rx_crc_hi_next;
	logic              rx_ready_reg;
	logic              cmd_pending_reg;
	logic              cmd_valid_reg;
	logic              cmd_valid_next;
	logic              rx_drop_reg;
	logic              rx_drop_next;
	logic [7:0]        rd_data_reg;
	logic [7:0]        rd_data_next;
	logic              rx_take;
	logic              rx_crc_ok;
	logic              rx_crc_init;
	logic              rx_crc_en;
	logic [15:0]       rx_crc;
	logic              mem_we;
	logic [7:0]        mem [REQ_MAX];
	scrf_tx_state_t    tx_state_reg;
	scrf_tx_state_t    tx_state_next;
	logic [15:0]       status_reg;
	logic [15:0]       status_next;
	logic [7:0]        tx_len_reg;
	logic [7:0]        tx_len_next;
	logic [7:0]        tx_idx_reg;
	logic [7:0]        tx_idx_next;
	logic              tx_valid_reg;
	logic              tx_valid_next;
	logic [7:0]        tx_data_reg;
	logic [7:0]        tx_data_next;
	logic              rsp_accept_reg;
	logic              rsp_accept_next;
	logic              tx_free;
	logic              tx_load;
	logic [7:0]        tx_byte;
	logic              tx_crc_init;
	logic              tx_crc_en;
	logic [15:0]       tx_crc;
	logic              tx_done;

	scrf_stream_if #(.W(FIFO_WIDTH)) app_in ();
	scrf_stream_if #(.W(FIFO_WIDTH)) app_out ();

	// Reset is released through two flops so every process leaves reset on the same edge.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	assign rx_ready     = rx_ready_reg;
	assign tx_valid     = tx_valid_reg;
	assign tx_data      = tx_data_reg;
	assign cmd_valid    = cmd_valid_reg;
	assign cmd_code     = rx_cmd_reg;
	assign cmd_len      = rx_len_reg;
	assign cmd_pending  = cmd_pending_reg;
	assign rx_drop      = rx_drop_reg;
	assign rd_data      = rd_data_reg;
	assign rsp_accept   = rsp_accept_reg;
	assign app_in.valid = app_tx_valid;
	assign app_in.data  = app_tx_data;
	assign app_tx_ready = app_in.ready;
	assign app_out.ready = tx_load && (tx_state_reg == TX_DAT);

	assign rx_take   = rx_valid && rx_ready_reg;
	assign rx_crc_ok = ({rx_crc_hi_reg, rx_data} == rx_crc);

	always_comb begin
		rx_state_next  = rx_state_reg;
		rx_len_next    = rx_len_reg;
		rx_cmd_next    = rx_cmd_reg;
		rx_idx_next    = rx_idx_reg;
		rx_crc_hi_next = rx_crc_hi_reg;
		cmd_valid_next = 1'b0;
		rx_drop_next   = 1'b0;
		rx_crc_init    = 1'b0;
		rx_crc_en      = 1'b0;
		mem_we         = 1'b0;
		rd_data_next   = (rd_addr < REQ_MAX) ? mem[rd_addr] : 8'h00;
		case (rx_state_reg)
			RX_HUNT: begin
				// Bytes other than the header are skipped so the link can resynchronise.
				if (rx_take && rx_data == HDR_BYTE) begin
					rx_crc_init   = 1'b1;
					rx_state_next = RX_LEN;
				end
			end
			RX_LEN: begin
				if (rx_take) begin
					if (rx_data > REQ_MAX) begin
						rx_drop_next  = 1'b1;
						rx_state_next = RX_HUNT;
					end else begin
						rx_len_next   = rx_data;
						rx_crc_en     = 1'b1;
						rx_state_next = RX_CMD;
					end
				end
			end
			RX_CMD: begin
				if (rx_take) begin
					rx_cmd_next   = rx_data;
					rx_crc_en     = 1'b1;
					rx_idx_next   = 8'h00;
					rx_state_next = (rx_len_reg == 8'h00) ? RX_CRH : RX_DAT;
				end
			end
			RX_DAT: begin
				if (rx_take) begin
					mem_we      = 1'b1;
					rx_crc_en   = 1'b1;
					rx_idx_next = rx_idx_reg + 8'h01;
					if (rx_idx_reg == rx_len_reg - 8'h01) begin
						rx_state_next = RX_CRH;
					end
				end
			end
			RX_CRH: begin
				if (rx_take) begin
					rx_crc_hi_next = rx_data;
					rx_state_next  = RX_CRL;
				end
			end
			RX_CRL: begin
				if (rx_take) begin
					if (rx_crc_ok) begin
						cmd_valid_next = 1'b1;
						rx_state_next  = RX_HOLD;
					end else begin
						rx_drop_next  = 1'b1;
						rx_state_next = RX_HUNT;
					end
				end
			end
			RX_HOLD: begin
				// rx_ready is held low here, so the host is held off and nothing is buffered meanwhile.
				if (tx_done) begin
					rx_state_next = RX_HUNT;
				end
			end
			default: begin
				rx_state_next = RX_HUNT;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_reg  <= RX_HUNT;
			rx_len_reg    <= 8'h00;
			rx_cmd_reg    <= 8'h00;
			rx_idx_reg    <= 8'h00;
			rx_crc_hi_reg <= 8'h00;
			rx_ready_reg  <= 1'b0;
			cmd_pending_reg <= 1'b1;
			cmd_valid_reg <= 1'b0;
			rx_drop_reg   <= 1'b0;
			rd_data_reg   <= 8'h00;
		end else begin
			rx_state_reg  <= rx_state_next;
			rx_len_reg    <= rx_len_next;
			rx_cmd_reg    <= rx_cmd_next;
			rx_idx_reg    <= rx_idx_next;
			rx_crc_hi_reg <= rx_crc_hi_next;
			rx_ready_reg  <= (rx_state_next != RX_HOLD);
			cmd_pending_reg <= (rx_state_next == RX_HOLD);
			cmd_valid_reg <= cmd_valid_next;
			rx_drop_reg   <= rx_drop_next;
			rd_data_reg   <= rd_data_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem[rx_idx_reg] <= rx_data;
		end
	end

	assign tx_free = !tx_valid_reg || tx_ready;

	always_comb begin
		tx_state_next   = tx_state_reg;
		status_next     = status_reg;
		tx_len_next     = tx_len_reg;
		tx_idx_next     = tx_idx_reg;
		rsp_accept_next = 1'b0;
		tx_load         = 1'b0;
		tx_byte         = 8'h00;
		tx_crc_init     = 1'b0;
		tx_crc_en       = 1'b0;
		tx_done         = 1'b0;
		case (tx_state_reg)
			TX_IDLE: begin
				if (rsp_start && rx_state_reg == RX_HOLD && rsp_len <= RSP_MAX) begin
					status_next     = rsp_status;
					tx_len_next     = rsp_len;
					tx_idx_next     = 8'h00;
					tx_crc_init     = 1'b1;
					rsp_accept_next = 1'b1;
					tx_state_next   = TX_HDR;
				end
			end
			TX_HDR: begin
				tx_load       = tx_free;
				tx_byte       = HDR_BYTE;
				tx_state_next = tx_free ? TX_LEN : TX_HDR;
			end
			TX_LEN: begin
				tx_load       = tx_free;
				tx_byte       = tx_len_reg;
				tx_crc_en     = tx_free;
				tx_state_next = tx_free ? TX_CMD : TX_LEN;
			end
			TX_CMD: begin
				tx_load       = tx_free;
				tx_byte       = rx_cmd_reg;
				tx_crc_en     = tx_free;
				tx_state_next = tx_free ? TX_STH : TX_CMD;
			end
			TX_STH: begin
				tx_load       = tx_free;
				tx_byte       = status_reg[15:8];
				tx_crc_en     = tx_free;
				tx_state_next = tx_free ? TX_STL : TX_STH;
			end
			TX_STL: begin
				tx_load   = tx_free;
				tx_byte   = status_reg[7:0];
				tx_crc_en = tx_free;
				if (tx_free) begin
					tx_state_next = (tx_len_reg == 8'h00) ? TX_CRH : TX_DAT;
				end
			end
			TX_DAT: begin
				// A starved buffer drops valid on the link rather than send a stale byte.
				tx_load   = tx_free && app_out.valid;
				tx_byte   = app_out.data;
				tx_crc_en = tx_load;
				if (tx_load) begin
					tx_idx_next = tx_idx_reg + 8'h01;
					if (tx_idx_reg == tx_len_reg - 8'h01) begin
						tx_state_next = TX_CRH;
					end
				end
			end
			TX_CRH: begin
				tx_load       = tx_free;
				tx_byte       = tx_crc[15:8];
				tx_state_next = tx_free ? TX_CRL : TX_CRH;
			end
			TX_CRL: begin
				tx_load       = tx_free;
				tx_byte       = tx_crc[7:0];
				tx_state_next = tx_free ? TX_END : TX_CRL;
			end
			TX_END: begin
				tx_done       = tx_free;
				tx_state_next = tx_free ? TX_IDLE : TX_END;
			end
			default: begin
				tx_state_next = TX_IDLE;
			end
		endcase
		tx_valid_next = tx_valid_reg && !tx_ready;
		tx_data_next  = tx_data_reg;
		if (tx_load) begin
			tx_valid_next = 1'b1;
			tx_data_next  = tx_byte;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg   <= TX_IDLE;
			status_reg     <= 16'h0000;
			tx_len_reg     <= 8'h00;
			tx_idx_reg     <= 8'h00;
			tx_valid_reg   <= 1'b0;
			tx_data_reg    <= 8'h00;
			rsp_accept_reg <= 1'b0;
		end else begin
			tx_state_reg   <= tx_state_next;
			status_reg     <= status_next;
			tx_len_reg     <= tx_len_next;
			tx_idx_reg     <= tx_idx_next;
			tx_valid_reg   <= tx_valid_next;
			tx_data_reg    <= tx_data_next;
			rsp_accept_reg <= rsp_accept_next;
		end
	end

	scrf_crc16 u_rx_crc (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.init    (rx_crc_init),
		.en      (rx_crc_en),
		.data    (rx_data),
		.crc     (rx_crc)
	);

	scrf_crc16 u_tx_crc (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.init    (tx_crc_init),
		.en      (tx_crc_en),
		.data    (tx_byte),
		.crc     (tx_crc)
	);

	scrf_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wr      (app_in),
		.rd      (app_out)
	);

	no_unsolicited_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(tx_valid_reg) |-> !rx_ready_reg && rx_state_reg == RX_HOLD)
		else $error("Response byte sent without a pending command.");
	good_packet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rx_take && rx_state_reg == RX_CRL && rx_crc_ok) |=> cmd_valid_reg && !rx_ready_reg ##1 !cmd_valid_reg)
		else $error("Good packet not delivered as a single locked command.");
	bad_crc_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rx_take && rx_state_reg == RX_CRL && !rx_crc_ok) |=> rx_drop_reg && !cmd_valid_reg && rx_ready_reg)
		else $error("Packet with bad checksum not discarded.");
	long_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rx_take && rx_state_reg == RX_LEN && rx_data > REQ_MAX) |=> rx_state_reg == RX_HUNT && rx_drop_reg)
		else $error("Overlong request not rejected.");
	header_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rx_take && rx_state_reg == RX_HUNT && rx_data == HDR_BYTE) |=> rx_crc == CRC_INIT)
		else $error("Header byte entered the checksum.");
	tx_header_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tx_state_reg == TX_HDR && tx_load) |=> tx_valid_reg && tx_data_reg == HDR_BYTE ##0 tx_state_reg == TX_LEN)
		else $error("Response does not open with the header byte.");
	tx_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tx_state_reg == TX_STH && tx_load) |=> tx_data_reg == status_reg[15:8])
		else $error("Status word high byte misplaced.");
	tx_crc_hi_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tx_state_reg == TX_CRH && tx_load) |=> tx_data_reg == $past(tx_crc[15:8]) && tx_state_reg == TX_CRL)
		else $error("Checksum high byte not sent after the counted bytes.");
	tx_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tx_state_reg == TX_DAT && tx_load && tx_idx_reg == tx_len_reg - 8'h01) |=> tx_state_reg == TX_CRH)
		else $error("Data byte count does not match the length field.");
	cmd_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmd_valid_reg |-> rx_len_reg <= REQ_MAX && rx_idx_reg == rx_len_reg)
		else $error("Delivered command longer than allowed.");
endmodule : scrf_framer

// *** verif/scrf_host_model.sv ***
`timescale 1ns/10ps
module scrf_host_model (
	// Clock.
	input  wire logic       clk_sys,
	// Request link toward the framer.
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       rx_ready,
	// Response link from the framer.
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] rsp_q[$];
	bit         stall_en;

	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b1;
		stall_en = 1'b0;
	end

	// Bytes leave in the order given, so the caller decides the checksum byte order.
	task automatic send_bytes(input logic [7:0] q[$]);
		foreach (q[i]) begin
			rx_valid <= 1'b1;
			rx_data  <= q[i];
			do @(posedge clk_sys); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		// A released line must not look like a held byte.
		rx_data  <= ~q[q.size()-1];
	endtask : send_bytes

	// The next request waits for the whole response, under a limit per command.
	task automatic wait_rsp(input int n, input int limit, output bit ok);
		ok = 1'b0;
		for (int c = 0; c < limit && !ok; c++) begin
			@(posedge clk_sys);
			ok = (rsp_q.size() >= n);
		end
	endtask : wait_rsp

	// A slow host stalls at random, which exercises the held output bytes.
	always @(posedge clk_sys) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			rsp_q.push_back(tx_data);
		end
		tx_ready <= stall_en ? 1'($urandom_range(1)) : 1'b1;
	end
endmodule : scrf_host_model

// *** verif/scrf_framer_tb.sv ***
`timescale 1ns/10ps
module scrf_framer_tb;
	import scrf_pkg::*;
	logic        clk_sys, resetn, rx_valid, rx_ready, tx_valid, tx_ready;
	logic        cmd_valid, cmd_pending, rx_drop, rsp_start, rsp_accept, app_tx_valid, app_tx_ready;
	logic [7:0]  rx_data, tx_data, cmd_code, cmd_len, rd_addr, rd_data, rsp_len, app_tx_data;
	logic [15:0] rsp_status;
	logic [7:0]  dat[$], pkt[$], exp_q[$];
	logic [7:0]  last_cmd, len, n;
	int          failures, samples_checked;
	bit          seen;

	scrf_framer dut_u (.clk_sys(clk_sys), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_pending(cmd_pending),
		.rx_drop(rx_drop), .rd_addr(rd_addr), .rd_data(rd_data), .rsp_start(rsp_start),
		.rsp_status(rsp_status), .rsp_len(rsp_len), .rsp_accept(rsp_accept), .app_tx_valid(app_tx_valid),
		.app_tx_data(app_tx_data), .app_tx_ready(app_tx_ready));

	scrf_host_model host_u (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	initial begin
		clk_sys = 1'b0;
	end
	always #2 clk_sys = ~clk_sys;

	function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {q[i], 8'h00};
			for (int b = 0; b < 8; b++)
				c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc_of

	// The checksum is taken before the header goes on the front.
	function automatic void frame(inout logic [7:0] q[$]);
		logic [15:0] c;
		c = crc_of(q);
		q.push_front(HDR_BYTE);
		q.push_back(c[15:8]);
		q.push_back(c[7:0]);
	endfunction : frame

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic complete_run();
		if (failures == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic push_app(input logic [7:0] b);
		app_tx_valid <= 1'b1;
		app_tx_data  <= b;
		do @(posedge clk_sys); while (app_tx_ready !== 1'b1);
	endtask : push_app

	task automatic send_req(input logic [7:0] cmd, input logic [7:0] ln, input bit bad);
		dat = {};
		repeat (ln) dat.push_back(8'($urandom));
		pkt = {ln, cmd, dat};
		frame(pkt);
		if (bad)
			pkt[pkt.size()-1] ^= 8'h01;
		host_u.send_bytes(pkt);
		@(posedge clk_sys);
		chk("cmd_valid", 16'(!bad), cmd_valid);
		chk("rx_drop", 16'(bad), rx_drop);
		chk("rx_ready", 16'(bad), rx_ready);
		if (!bad) begin
			last_cmd = cmd;
			chk("cmd_code", cmd, cmd_code);
			chk("cmd_len", ln, cmd_len);
			for (int i = 0; i < ln; i++) begin
				rd_addr <= 8'(i);
				repeat (2) @(posedge clk_sys);
				chk("rd_data", dat[i], rd_data);
			end
			rd_addr <= REQ_MAX;
			repeat (2) @(posedge clk_sys);
			chk("rd_data", 16'h0000, rd_data);
			chk("cmd_pending", 16'h0001, cmd_pending);
		end
	endtask : send_req

	task automatic try_refused(input logic [7:0] ln);
		host_u.rsp_q = {};
		rsp_start <= 1'b1;
		rsp_len   <= ln;
		@(posedge clk_sys);
		rsp_start <= 1'b0;
		@(posedge clk_sys);
		chk("rsp_accept", 16'h0000, rsp_accept);
		repeat (10) @(posedge clk_sys);
		chk("tx_count", 16'h0000, 16'(host_u.rsp_q.size()));
	endtask : try_refused

	task automatic respond(input logic [15:0] st, input logic [7:0] ln, input bit prefill);
		int start;
		bit ok;
		dat = {};
		repeat (ln) dat.push_back(8'($urandom));
		exp_q = {ln, last_cmd, st[15:8], st[7:0], dat};
		frame(exp_q);
		host_u.rsp_q = {};
		start = 0;
		if (prefill) begin
			// Nothing drains before the response starts, so the buffer must refuse the ninth byte.
			for (start = 0; start < FIFO_DEPTH; start++)
				push_app(dat[start]);
			app_tx_valid <= 1'b0;
			repeat (2) @(posedge clk_sys);
			chk("app_tx_ready", 16'h0000, app_tx_ready);
		end
		fork
			begin
				for (int k = start; k < ln; k++)
					push_app(dat[k]);
				app_tx_valid <= 1'b0;
			end
			begin
				rsp_start  <= 1'b1;
				rsp_status <= st;
				rsp_len    <= ln;
				@(posedge clk_sys);
				rsp_start <= 1'b0;
				@(posedge clk_sys);
				chk("rsp_accept", 16'h0001, rsp_accept);
			end
		join
		host_u.wait_rsp(exp_q.size(), 4000, ok);
		chk("rsp_done", 16'h0001, 16'(ok));
		@(posedge clk_sys);
		chk("rsp_size", 16'(exp_q.size()), 16'(host_u.rsp_q.size()));
		foreach (exp_q[k]) begin
			if (k < host_u.rsp_q.size())
				chk("rsp_byte", exp_q[k], host_u.rsp_q[k]);
		end
		chk("rx_ready", 16'h0001, rx_ready);
		chk("cmd_pending", 16'h0000, cmd_pending);
		chk("tx_valid", 16'h0000, tx_valid);
	endtask : respond

	initial begin
		void'($urandom(32'h1E22));
		resetn       = 1'b0;
		rd_addr      = 8'h00;
		rsp_start    = 1'b0;
		rsp_status   = 16'h0000;
		rsp_len      = 8'h00;
		app_tx_valid = 1'b0;
		app_tx_data  = 8'h00;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("rx_ready", 16'h0001, rx_ready);
		try_refused(8'h00);
		// A stray byte ahead of the header must be hunted past, not taken as a header.
		host_u.send_bytes({8'h3C, HDR_BYTE, 8'hFB});
		seen = 1'b0;
		repeat (3) begin
			@(posedge clk_sys);
			if (rx_drop === 1'b1)
				seen = 1'b1;
		end
		chk("rx_drop", 16'h0001, 16'(seen));
		send_req(8'h3C, 8'h04, 1'b1);
		send_req(8'h3C, 8'h04, 1'b0);
		try_refused(8'hF9);
		host_u.stall_en = 1'b1;
		respond(16'hC35A, 8'h14, 1'b1);
		for (int it = 0; it < 12; it++) begin
			len = (it == 0) ? 8'h00 : (it == 1) ? REQ_MAX : 8'($urandom_range(40));
			n   = (it == 0) ? 8'h00 : (it == 1) ? RSP_MAX : 8'($urandom_range(40));
			host_u.stall_en = 1'($urandom_range(1));
			send_req(8'($urandom), len, 1'b0);
			respond(16'($urandom), n, 1'b0);
		end
		complete_run();
	end

	// The longest run needs only a small part of this span.
	initial begin
		#200000;
		failures++;
		complete_run();
	end
endmodule : scrf_framer_tb
